/* include/dasa_pipe_if.sv */
// Carrier between the stage and one of its control delay paths.
// Assumes dasa_pkg is compiled first.
interface dasa_pipe_if #(parameter int W = 2);
    logic [W-1:0]        d;      // Undelayed control
    logic [W-1:0]        q;      // Delayed control
    dasa_pkg::dasa_depth_t depth; // Number of register stages

    // Stage side drives input and depth
    modport stage (output d, output depth, input q);
    // Delay path side
    modport pipe (input d, input depth, output q);
endinterface : dasa_pipe_if

/* include/dasa_pkg.sv */
// Constants, field layout and types of the add/sub/accumulate stage.
// Assumes a single clock domain and a word-aligned Avalon-MM slave.
package dasa_pkg;
    // ------------------------------------------------------------
    // Datapath widths
    // ------------------------------------------------------------
    localparam int PROD_W = 36;             // One 18x18 product
    localparam int HALF_W = 18;             // One 9x9 product
    localparam int ACC_W  = 52;             // Accumulator and result lane
    localparam int LANE_W = 26;             // Half lane in 9x9 mode
    localparam int BUS_W  = 32;             // Avalon data width
    localparam int ADR_W  = 5;              // Avalon byte address width
    localparam int HI_W   = ACC_W - BUS_W;  // Upper result word width

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADR_W-1:0] OFS_CTRL = 5'h00; // Mode and depths
    localparam logic [ADR_W-1:0] OFS_STAT = 5'h04; // Overflow flags
    localparam logic [ADR_W-1:0] OFS_R0L  = 5'h08; // Lane 0 low word
    localparam logic [ADR_W-1:0] OFS_R0H  = 5'h0C; // Lane 0 high word
    localparam logic [ADR_W-1:0] OFS_R1L  = 5'h10; // Lane 1 low word
    localparam logic [ADR_W-1:0] OFS_R1H  = 5'h14; // Lane 1 high word

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_W   = 10;           // Implemented control bits
    localparam int CB_ACC   = 0;            // Accumulate mode
    localparam int CB_SUM   = 1;            // Summation stage enable
    localparam int CB_NINE  = 2;            // 9x9 product mode
    localparam int CB_ADD_D = 4;            // Add/sub select depth, 2 bits
    localparam int CB_SGN_D = 6;            // Sign indicator depth, 2 bits
    localparam int CB_LD_D  = 8;            // Load select depth, 2 bits
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

    // Register depth of a control path
    typedef enum logic [1:0] {
        DASA_D0 = 2'b00,
        DASA_D1 = 2'b01,
        DASA_D2 = 2'b10
    } dasa_depth_t;

    // Bus answer state
    typedef enum logic {
        DASA_IDLE = 1'b0,
        DASA_ACK  = 1'b1
    } dasa_bus_t;
endpackage : dasa_pkg

/* rtl/dasa_pipe.sv */
// Control delay path of zero, one or two register stages.
// Assumes one clock, synchronous active-low reset, shared enable and clear.
module dasa_pipe #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_b_i,
    // Register control
    input  wire logic ena_i,
    input  wire logic clr_i,
    // Control path
    dasa_pipe_if.pipe p
);
    logic [W-1:0] stg1;  // First register stage
    logic [W-1:0] stg2;  // Second register stage

    // ------------------------------------------------------------
    // Registers advance only on enabled edges
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i || clr_i) begin
            stg1 <= '0;
            stg2 <= '0;
        end else if (ena_i) begin
            stg1 <= p.d;
            stg2 <= stg1;
        end
    end

    // ------------------------------------------------------------
    // Tap select; reserved depth code acts as two stages
    // ------------------------------------------------------------
    assign p.q = (p.depth == dasa_pkg::DASA_D0) ? p.d :
                 (p.depth == dasa_pkg::DASA_D1) ? stg1 : stg2;
endmodule : dasa_pipe

/* rtl/dasa_stage.sv */
// First adder level of the arithmetic output stage: add/sub, accumulate,
// optional summation, registered overflow, Avalon-MM control slave.
// Assumes products arrive synchronous to core_clk_i from the multipliers.
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
module dasa_stage (
    // Clock and reset
    input  wire logic                       core_clk_i,
    input  wire logic                       rst_b_i,
    // Avalon-MM slave
    input  wire logic [dasa_pkg::ADR_W-1:0] avs_address_i,
    input  wire logic                       avs_read_i,
    input  wire logic                       avs_write_i,
    input  wire logic [dasa_pkg::BUS_W-1:0] avs_writedata_i,
    output logic      [dasa_pkg::BUS_W-1:0] avs_readdata_o,
    output logic                            avs_waitrequest_o,
    // Register control
    input  wire logic                       ena_i,
    input  wire logic                       clr_i,
    // Products and controls from the multipliers
    input  wire logic [3:0][dasa_pkg::PROD_W-1:0] prod_i,
    input  wire logic [1:0]                 addnsub_i,
    input  wire logic                       signa_i,
    input  wire logic                       signb_i,
    input  wire logic [1:0]                 accum_sload_i,
    // Results
    output logic      [1:0][dasa_pkg::ACC_W-1:0] res_o,
    output logic      [1:0]                 overflow_o
);
    localparam int AW = dasa_pkg::ACC_W;
    localparam int LW = dasa_pkg::LANE_W;
    localparam int PW = dasa_pkg::PROD_W;
    localparam int HW = dasa_pkg::HALF_W;
    localparam int BW = dasa_pkg::BUS_W;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Extends an 18x18 product to lane width
    function automatic logic [AW-1:0] ext_prod(input logic [PW-1:0] p,
                                               input logic s);
        ext_prod = {{(AW-PW){s & p[PW-1]}}, p};
    endfunction : ext_prod

    // Extends a 9x9 product to lane width
    function automatic logic [AW-1:0] ext_half(input logic [HW-1:0] p,
                                               input logic s);
        ext_half = {{(AW-HW){s & p[HW-1]}}, p};
    endfunction : ext_half

    // Add when select high, subtract when low
    function automatic logic [AW-1:0] add_sub(input logic [AW-1:0] a,
                                              input logic [AW-1:0] b,
                                              input logic add);
        add_sub = add ? a + b : a - b;
    endfunction : add_sub

    // Accumulator step, one guard bit above the lane
    function automatic logic [AW:0] acc_step(input logic [AW-1:0] a,
                                             input logic [AW-1:0] b,
                                             input logic add,
                                             input logic s);
        logic [AW:0] ax;
        logic [AW:0] bx;
        ax = {s & a[AW-1], a};
        bx = {s & b[AW-1], b};
        acc_step = add ? ax + bx : ax - bx;
    endfunction : acc_step

    // Range check: signed uses the two top bits, unsigned the guard
    function automatic logic out_of_range(input logic [AW:0] r,
                                          input logic s);
        out_of_range = s ? (r[AW] ^ r[AW-1]) : r[AW];
    endfunction : out_of_range

    // ------------------------------------------------------------
    // Control and status registers
    // ------------------------------------------------------------
    logic [dasa_pkg::CTRL_W-1:0] ctrl;        // Mode and depths
    dasa_pkg::dasa_bus_t         bus_st;      // Bus answer state
    logic [BW-1:0]               rd_q;        // Read data register
    logic [BW-1:0]               next_rd;     // Read data mux

    // Named fields of the control register
    wire logic acc_mode = ctrl[dasa_pkg::CB_ACC];
    wire logic sum_mode = ctrl[dasa_pkg::CB_SUM];
    wire logic nine     = ctrl[dasa_pkg::CB_NINE];

    // ------------------------------------------------------------
    // Control delay paths
    // ------------------------------------------------------------
    dasa_pipe_if #(.W(2)) add_p ();   // Two add/sub selects
    dasa_pipe_if #(.W(2)) sgn_p ();   // Sign A and sign B
    dasa_pipe_if #(.W(2)) ld_p  ();   // Two load selects

    // Only two selects exist; the pair covers every mode
    assign add_p.d = addnsub_i;
    assign add_p.depth = dasa_pkg::dasa_depth_t'(
        ctrl[dasa_pkg::CB_ADD_D +: 2]);
    // Same sign inputs that steer the multipliers
    assign sgn_p.d = {signb_i, signa_i};
    assign sgn_p.depth = dasa_pkg::dasa_depth_t'(
        ctrl[dasa_pkg::CB_SGN_D +: 2]);
    assign ld_p.d = accum_sload_i;
    assign ld_p.depth = dasa_pkg::dasa_depth_t'(
        ctrl[dasa_pkg::CB_LD_D +: 2]);

    // Add/sub select delay
    dasa_pipe #(.W(2)) u_add_pipe (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .ena_i      (ena_i),
        .clr_i      (clr_i),
        .p          (add_p.pipe)
    );

    // Sign indicator delay
    dasa_pipe #(.W(2)) u_sgn_pipe (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .ena_i      (ena_i),
        .clr_i      (clr_i),
        .p          (sgn_p.pipe)
    );

    // Load select delay
    dasa_pipe #(.W(2)) u_ld_pipe (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .ena_i      (ena_i),
        .clr_i      (clr_i),
        .p          (ld_p.pipe)
    );

    // ------------------------------------------------------------
    // Operand preparation
    // ------------------------------------------------------------
    // Product is signed when either operand is signed
    wire logic sgn = sgn_p.q[0] | sgn_p.q[1];
    wire logic [1:0] as = add_p.q;      // Delayed add/sub selects
    wire logic [1:0] ld = ld_p.q;       // Delayed load selects

    logic [3:0][AW-1:0] e18;            // Extended 18x18 products
    logic [7:0][AW-1:0] e9;             // Extended 9x9 products

    // Wide products, and each split into two narrow products
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            e18[k]       = ext_prod(prod_i[k], sgn);
            e9[2*k]      = ext_half(prod_i[k][HW-1:0], sgn);
            e9[2*k+1]    = ext_half(prod_i[k][PW-1:HW], sgn);
        end
    end

    // ------------------------------------------------------------
    // First-level adders
    // ------------------------------------------------------------
    // 18x18: each adder on its own select
    wire logic [AW-1:0] a18_0 = add_sub(e18[0], e18[1], as[0]);
    wire logic [AW-1:0] a18_1 = add_sub(e18[2], e18[3], as[1]);
    // 9x9: products 0 to 3 on select 0, products 4 to 7 on select 1
    wire logic [AW-1:0] a9_0 = add_sub(e9[0], e9[1], as[0]);
    wire logic [AW-1:0] a9_1 = add_sub(e9[2], e9[3], as[0]);
    wire logic [AW-1:0] a9_2 = add_sub(e9[4], e9[5], as[1]);
    wire logic [AW-1:0] a9_3 = add_sub(e9[6], e9[7], as[1]);

    // ------------------------------------------------------------
    // Summation stage
    // ------------------------------------------------------------
    // One sum of four wide products
    wire logic [AW-1:0] sum18 = a18_0 + a18_1;
    // Two sums, each of four narrow products
    wire logic [AW-1:0] sum9_0 = a9_0 + a9_1;
    wire logic [AW-1:0] sum9_1 = a9_2 + a9_3;

    // ------------------------------------------------------------
    // Accumulators, lane k takes wide product 2k
    // ------------------------------------------------------------
    // Running total fed back as the first operand
    wire logic [AW:0] acc0 = acc_step(res_o[0], e18[0], as[0], sgn);
    wire logic [AW:0] acc1 = acc_step(res_o[1], e18[2], as[1], sgn);

    // ------------------------------------------------------------
    // Next result selection
    // ------------------------------------------------------------
    logic [1:0][AW-1:0] next_res;   // Next lane values
    logic [1:0]         next_ovf;   // Next overflow flags

    // Mode priority: accumulate, then summation, then plain adders
    always_comb begin
        next_ovf = 2'h0;
        if (acc_mode) begin
            // Load replaces the total with the product
            next_res[0] = ld[0] ? e18[0] : acc0[AW-1:0];
            next_res[1] = ld[1] ? e18[2] : acc1[AW-1:0];
            // Range check on a real accumulate only
            next_ovf[0] = ~ld[0] & out_of_range(acc0, sgn);
            next_ovf[1] = ~ld[1] & out_of_range(acc1, sgn);
        end else if (sum_mode) begin
            // Adder results routed through the summation stage
            if (nine) begin
                next_res[0] = sum9_0;
                next_res[1] = sum9_1;
            end else begin
                next_res[0] = sum18;
                next_res[1] = '0;
            end
        end else if (nine) begin
            // Two narrow results packed per lane
            next_res[0] = {a9_1[LW-1:0], a9_0[LW-1:0]};
            next_res[1] = {a9_3[LW-1:0], a9_2[LW-1:0]};
        end else begin
            // One wide result per lane
            next_res[0] = a18_0;
            next_res[1] = a18_1;
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    // Overflow reloads every enabled edge, so it never sticks
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i || clr_i) begin
            res_o      <= '0;
            overflow_o <= 2'h0;
        end else if (ena_i) begin
            res_o      <= next_res;
            overflow_o <= next_ovf;
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------
    // Each request waits one cycle, then completes
    wire logic req = avs_read_i | avs_write_i;
    wire logic acc_now = req & (bus_st == dasa_pkg::DASA_ACK);
    wire logic wr_ctrl = acc_now & avs_write_i &
                         (avs_address_i == dasa_pkg::OFS_CTRL);

    assign avs_waitrequest_o = req & (bus_st == dasa_pkg::DASA_IDLE);
    assign avs_readdata_o    = rd_q;

    // Read mux; unmapped offsets read as zero
    always_comb begin
        case (avs_address_i)
            dasa_pkg::OFS_CTRL: next_rd = BW'(ctrl);
            dasa_pkg::OFS_STAT: next_rd = BW'(overflow_o);
            dasa_pkg::OFS_R0L:  next_rd = res_o[0][BW-1:0];
            dasa_pkg::OFS_R0H:  next_rd = BW'(res_o[0][AW-1:BW]);
            dasa_pkg::OFS_R1L:  next_rd = res_o[1][BW-1:0];
            dasa_pkg::OFS_R1H:  next_rd = BW'(res_o[1][AW-1:BW]);
            default:            next_rd = '0;
        endcase
    end

    // Answer state machine
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            bus_st <= dasa_pkg::DASA_IDLE;
        end else begin
            case (bus_st)
                dasa_pkg::DASA_IDLE:
                    bus_st <= req ? dasa_pkg::DASA_ACK : dasa_pkg::DASA_IDLE;
                dasa_pkg::DASA_ACK:
                    bus_st <= dasa_pkg::DASA_IDLE;
                default:
                    bus_st <= dasa_pkg::DASA_IDLE;
            endcase
        end
    end

    // Read data captured while waitrequest is high
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            rd_q <= '0;
        end else if (avs_read_i && bus_st == dasa_pkg::DASA_IDLE) begin
            rd_q <= next_rd;
        end
    end

    // Control register; written at the completing edge
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ctrl <= dasa_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl <= avs_writedata_i[dasa_pkg::CTRL_W-1:0];
        end
    end
endmodule : dasa_stage

/* sim/dasa_mult_model.sv */
// Multiplier stage model: four 18x18 or eight 9x9 products per cycle.
// Assumes operands change after a clock edge; products follow at once.
module dasa_mult_model (
    // Mode and signedness
    input  wire logic             nine_i,
    input  wire logic             signa_i,
    input  wire logic             signb_i,
    // Operands and products
    input  wire logic [3:0][17:0] a_i,
    input  wire logic [3:0][17:0] b_i,
    output logic      [3:0][35:0] prod_o
);
    logic [35:0] full;   // One 18x18 product
    logic [17:0] hi, lo; // Two 9x9 products
    // Signedness shared with the stage, taken before its sign delay
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            if (signa_i | signb_i) begin
                full = $signed(a_i[k]) * $signed(b_i[k]);
                hi = $signed(a_i[k][17:9]) * $signed(b_i[k][17:9]);
                lo = $signed(a_i[k][8:0]) * $signed(b_i[k][8:0]);
            end else begin
                full = a_i[k] * b_i[k];
                hi = a_i[k][17:9] * b_i[k][17:9];
                lo = a_i[k][8:0] * b_i[k][8:0];
            end
            prod_o[k] = nine_i ? {hi, lo} : full;
        end
    end
endmodule : dasa_mult_model

/* sim/dasa_stage_chk.sv */
// Checker of the add/sub/accumulate stage on its top ports.
// Assumes CTRL changes only through Avalon writes seen here.
module dasa_stage_chk (
    // Clock and reset
    input wire logic                             core_clk_i,
    input wire logic                             rst_b_i,
    // Avalon-MM slave
    input wire logic [dasa_pkg::ADR_W-1:0]       avs_address_i,
    input wire logic                             avs_read_i,
    input wire logic                             avs_write_i,
    input wire logic [dasa_pkg::BUS_W-1:0]       avs_writedata_i,
    input wire logic                             avs_waitrequest_o,
    // Datapath
    input wire logic                             ena_i,
    input wire logic                             clr_i,
    input wire logic [3:0][dasa_pkg::PROD_W-1:0] prod_i,
    input wire logic [1:0]                       addnsub_i,
    input wire logic                             signa_i,
    input wire logic                             signb_i,
    input wire logic [1:0]                       accum_sload_i,
    input wire logic [1:0][dasa_pkg::ACC_W-1:0]  res_o,
    input wire logic [1:0]                       overflow_o
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic [9:0]            ctrl;                   // Shadow of CTRL
    wire logic             sg = signa_i | signb_i; // Product signed
    wire logic             dp = ena_i && !clr_i;   // Datapath edge
    wire logic [3:0][52:0] e;                      // Extended products
    wire logic [52:0]      pl0 = addnsub_i[0] ? e[0] + e[1] : e[0] - e[1];
    wire logic [52:0]      pl1 = addnsub_i[1] ? e[2] + e[3] : e[2] - e[3];
    wire logic [52:0]      sum = pl0 + pl1;        // Four-product sum
    wire logic [52:0]      acc0 = {1'h0, res_o[0]} + {17'h0, prod_i[0]};
    wire logic [52:0]      sub1 = {1'h0, res_o[1]} - {17'h0, prod_i[2]};
    for (genvar k = 0; k < 4; k++) begin : g_ext
        assign e[k] = {{17{sg & prod_i[k][35]}}, prod_i[k]};
    end
    // Follow completed CTRL writes
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i)
            ctrl <= 10'h000;
        else if (avs_write_i && !avs_waitrequest_o && avs_address_i == dasa_pkg::OFS_CTRL)
            ctrl <= avs_writedata_i[9:0];
    end
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    AST_WAIT_ONE: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o ##1 avs_read_i || avs_write_i
        |-> !avs_waitrequest_o) else $error("waitrequest too long");
    AST_CLEAR: assert property (
        clr_i |=> res_o == 104'h0 && overflow_o == 2'h0) else $error("clear missed");
    AST_FREEZE: assert property (
        !ena_i && !clr_i |=> $stable(res_o) && $stable(overflow_o)) else $error("moved");
    AST_PLAIN: assert property (
        ctrl == 10'h000 && dp |=> res_o[0] == $past(pl0[51:0]) && res_o[1] == $past(pl1[51:0]))
        else $error("plain result wrong");
    AST_SUM: assert property (
        ctrl == 10'h002 && dp |=> res_o[0] == $past(sum[51:0]) && res_o[1] == 52'h0)
        else $error("sum wrong");
    AST_LOAD: assert property (
        ctrl == 10'h001 && dp && accum_sload_i[0] |=> res_o[0] == $past(e[0][51:0])
        && !overflow_o[0]) else $error("load wrong");
    AST_ACC_ADD: assert property (
        ctrl == 10'h001 && dp && !sg && !accum_sload_i[0] && addnsub_i[0]
        |=> res_o[0] == $past(acc0[51:0]) && overflow_o[0] == $past(acc0[52]))
        else $error("add wrong");
    AST_ACC_SUB: assert property (
        ctrl == 10'h001 && dp && !sg && !accum_sload_i[1] && !addnsub_i[1]
        |=> res_o[1] == $past(sub1[51:0]) && overflow_o[1] == $past(sub1[52]))
        else $error("subtract wrong");
endmodule : dasa_stage_chk

bind dasa_stage dasa_stage_chk i_dasa_stage_chk (
    .core_clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_waitrequest_o, .ena_i, .clr_i, .prod_i, .addnsub_i, .signa_i, .signb_i,
    .accum_sload_i, .res_o, .overflow_o
);

/* sim/dasa_stage_tb_top.sv */
// Testbench of the add/sub/accumulate stage: Avalon tasks, datapath steps.
// Assumes the multiplier model feeds products without latency.
module dasa_stage_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Signals and tasks
    // ------------------------------------------------------------
    localparam logic [71:0] A53 = {18'h3, 18'h5, 18'h3, 18'h5};         // 18x18 operands
    localparam logic [71:0] A9  = {18'h204, 18'h605, 18'h204, 18'h605}; // 9x9 operands
    localparam logic [71:0] AM  = {18'h0, 18'h3FFFF, 18'h0, 18'h3FFFF}; // Large operands
    logic core_clk_i = 1'h0, rst_b_i = 1'h0, ena_i = 1'h0, clr_i = 1'h0;
    logic avs_read_i = 1'h0, avs_write_i = 1'h0, signa_i = 1'h0, signb_i = 1'h0, nine_i = 1'h0;
    logic [4:0]       avs_address_i   = 5'h00;
    logic [31:0]      avs_writedata_i = 32'h0;
    logic [1:0]       addnsub_i = 2'h0, accum_sload_i = 2'h0;
    logic [3:0][17:0] a_i = 72'h0, b_i = 72'h0;
    logic [31:0]      rdata;                                  // Last read data
    logic [1:0]       seq [6] = '{2'h1, 2'h3, 2'h0, 2'h0, 2'h3, 2'h2}; // Select sequence
    wire logic [31:0]       avs_readdata_o;
    wire logic              avs_waitrequest_o;
    wire logic [3:0][35:0]  prod_i;
    wire logic [1:0][51:0]  res_o;
    wire logic [1:0]        overflow_o;
    int mismatches = 0, n_tests = 0;
    dasa_stage i_dasa_stage (
        .core_clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .ena_i, .clr_i, .prod_i,
        .addnsub_i, .signa_i, .signb_i, .accum_sload_i, .res_o, .overflow_o
    );
    dasa_mult_model i_dasa_mult_model (
        .nine_i, .signa_i, .signb_i, .a_i, .b_i, .prod_o(prod_i)
    );
    always #12.5 core_clk_i = ~core_clk_i;
    // Compare and count
    task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
        n_tests++;
        if (got !== ex) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'h0);
        rdata = avs_readdata_o;
        chk("waits", 64'h2, 64'(n));
        avs_write_i <= 1'h0;
        avs_read_i <= 1'h0;
    endtask : bus
    task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] ex);
        bus(1'h0, a, 32'h0);
        chk(nm, 64'(ex), 64'(rdata));
    endtask : rchk
    task automatic cres(input logic [51:0] r0, input logic [51:0] r1);
        chk("res0", 64'(r0), 64'(res_o[0]));
        chk("res1", 64'(r1), 64'(res_o[1]));
    endtask : cres
    task automatic mode(input logic [31:0] c);
        bus(1'h1, dasa_pkg::OFS_CTRL, c);
        nine_i <= c[2];
    endtask : mode
    // One enabled datapath edge
    task automatic step(input logic [71:0] a, input logic [17:0] bb,
                        input logic [1:0] sel, sld, input logic [1:0] sg);
        @(posedge core_clk_i);
        a_i <= a;
        b_i <= {4{bb}};
        addnsub_i <= sel;
        accum_sload_i <= sld;
        signa_i <= sg[0];
        signb_i <= sg[1];
        ena_i <= 1'h1;
        @(posedge core_clk_i);
        ena_i <= 1'h0;
        #1;
    endtask : step
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    // Watchdog
    initial begin
        repeat (20000) @(posedge core_clk_i);
        mismatches++;
        finish_test;
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge core_clk_i);
        rst_b_i <= 1'h1;
        rchk("ctrl", dasa_pkg::OFS_CTRL, 32'h0);
        bus(1'h1, dasa_pkg::OFS_CTRL, 32'hFFFFFFFF);
        rchk("ctrl", dasa_pkg::OFS_CTRL, 32'h3FF);
        bus(1'h1, dasa_pkg::OFS_STAT, 32'h3);
        rchk("stat", dasa_pkg::OFS_STAT, 32'h0);
        rchk("hole", 5'h18, 32'h0);
        for (int d = 0; d < 3; d++) begin
            mode(32'(d << 4));
            for (int i = 0; i < 6; i++) begin
                step(A53, 18'h1, seq[i], 2'h0, 1'h0);
                if (i >= d) cres(seq[i-d][0] ? 52'h8 : 52'h2, seq[i-d][1] ? 52'h8 : 52'h2);
            end
        end
        mode(32'h4);
        for (int k = 0; k < 4; k++) begin
            step(A9, 18'h201, 2'(k), 2'h0, 1'h0);
            cres(k[0] ? 52'h14000008 : 52'hC000002, k[1] ? 52'h14000008 : 52'hC000002);
        end
        mode(32'h2);
        step(A53, 18'h1, 2'h1, 2'h0, 1'h0);
        cres(52'hA, 52'h0);
        mode(32'h6);
        step(A9, 18'h201, 2'h1, 2'h0, 1'h0);
        cres(52'hD, 52'h5);
        mode(32'h1);
        step({18'h0, 18'h7, 18'h0, 18'h64}, 18'h1, 2'h3, 2'h3, 1'h0);
        cres(52'h64, 52'h7);
        step({18'h0, 18'h2, 18'h0, 18'h10}, 18'h1, 2'h1, 2'h0, 1'h0);
        cres(52'h74, 52'h5);
        step({18'h0, 18'h6, 18'h0, 18'h0}, 18'h1, 2'h1, 2'h0, 1'h0);
        cres(52'h74, 52'hFFFFFFFFFFFFF);
        chk("overflow", 64'h2, 64'(overflow_o));
        rchk("stat", dasa_pkg::OFS_STAT, 32'h2);
        rchk("r1l", dasa_pkg::OFS_R1L, 32'hFFFFFFFF);
        rchk("r1h", dasa_pkg::OFS_R1H, 32'hFFFFF);
        step({18'h0, 18'h1, 18'h0, 18'h0}, 18'h1, 2'h3, 2'h2, 1'h0);
        cres(52'h74, 52'h1);
        chk("overflow", 64'h0, 64'(overflow_o));
        step({18'h0, 18'h2, 18'h0, 18'h0}, 18'h1, 2'h1, 2'h0, 1'h1);
        cres(52'h74, 52'hFFFFFFFFFFFFF);
        chk("overflow", 64'h0, 64'(overflow_o));
        mode(32'h101);
        step({18'h0, 18'h9, 18'h0, 18'h9}, 18'h1, 2'h3, 2'h3, 1'h0);
        step({18'h0, 18'h4, 18'h0, 18'h4}, 18'h1, 2'h3, 2'h0, 1'h0);
        cres(52'h4, 52'h4);
        step({18'h0, 18'h1, 18'h0, 18'h1}, 18'h1, 2'h3, 2'h0, 1'h0);
        cres(52'h5, 52'h5);
        mode(32'h40);
        step(AM, 18'h3FFFF, 2'h3, 2'h0, 2'h2);
        step(AM, 18'h3FFFF, 2'h3, 2'h0, 1'h0);
        cres(52'hFFFFFFFF80001, 52'hFFFFFFFF80001);
        step(AM, 18'h3FFFF, 2'h3, 2'h0, 1'h0);
        cres(52'h0000FFFF80001, 52'h0000FFFF80001);
        @(posedge core_clk_i);
        clr_i <= 1'h1;
        @(posedge core_clk_i);
        clr_i <= 1'h0;
        #1;
        cres(52'h0, 52'h0);
        mode(32'h201);
        step({18'h0, 18'h9, 18'h0, 18'h9}, 18'h1, 2'h3, 2'h3, 1'h0);
        step({18'h0, 18'h4, 18'h0, 18'h4}, 18'h1, 2'h3, 2'h0, 1'h0);
        step({18'h0, 18'h1, 18'h0, 18'h1}, 18'h1, 2'h3, 2'h0, 1'h0);
        cres(52'h1, 52'h1);
        finish_test;
    end
endmodule : dasa_stage_tb_top
